// ---- hdl/fes_pkg.sv ----
/*
  Constants for the fetch/execute sequencer: phase codes, vectors,
  address and word widths.
  Assumes one clock (clk) that stands for the oscillator input.
*/
// How it works
// - The clock is divided by four into four non-overlapping phases that make one instruction cycle.
// - The program counter steps in the first phase, which starts the next fetch.
// - The word at the program counter is read and captured in the fourth phase.
// - Fetch and execute each take one cycle and overlap, giving one instruction per cycle.
// - The fetched word enters the instruction register in the first phase and runs in phases two to four.
// - The operand is read in phase two and the result written in phase four.
// - A change of program counter costs two cycles; the prefetched word is flushed as a no-op.
// - The program counter is 13 bits wide over an 8K by 14 space.
// - Only the low 4K words exist and higher addresses wrap into them.
// - Reset starts at word zero and interrupt entry goes to word four.
// - Instruction words are 14 bits, fetched in one cycle on their own bus.
// - A cycle-rate output runs at one quarter of the input clock.
package fes_pkg;
  localparam int PC_W   = 13;
  localparam int WORD_W = 14;
  localparam int IMPL_W = 12;
  localparam logic [PC_W-1:0]   RESET_VEC = 13'h0000;
  localparam logic [PC_W-1:0]   INTR_VEC  = 13'h0004;
  localparam logic [WORD_W-1:0] NOP_WORD  = 14'h0000;
  typedef enum logic [1:0] {
    PH_FIRST  = 2'b00,
    PH_SECOND = 2'b01,
    PH_THIRD  = 2'b10,
    PH_FOURTH = 2'b11
  } fes_phase_t;
endpackage

// ---- hdl/fes_sequencer.sv ----
/*
  Fetch/execute sequencer: phase generator, program counter, prefetch
  pipeline with flush, and phase-timed data memory strobes.
  Assumes program memory answers combinationally within one phase and
  that the decoder reports a branch while a word executes.
*/
module fes_sequencer
  import fes_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Program memory
  output logic [IMPL_W-1:0]      prog_addr,
  input  wire logic [WORD_W-1:0] prog_data,
  // Decoder and control
  input  wire logic              branch_take,
  input  wire logic [PC_W-1:0]   branch_target,
  input  wire logic              intr_enter,
  // Execution view
  output logic [WORD_W-1:0]      instr_word,
  output logic                   instr_valid,
  output logic [PC_W-1:0]        pc,
  output logic                   phase_first,
  output logic                   phase_second,
  output logic                   phase_third,
  output logic                   phase_fourth,
  // Data memory strobes
  output logic                   data_read,
  output logic                   data_write,
  // Cycle-rate output
  output logic                   cycle_rate_output
);

  // Phase group
  fes_phase_t        phase;
  fes_phase_t        next_phase;
  logic              next_rate;
  // Redirect group
  logic              redirect_pend;
  logic              next_redirect_pend;
  logic [PC_W-1:0]   target;
  logic [PC_W-1:0]   next_target;
  logic              intr_req;
  logic              branch_req;
  logic              redirect;
  // Boot group
  logic              boot;
  logic              next_boot;
  // Program counter group
  logic [PC_W-1:0]   next_pc;
  logic [PC_W-1:0]   pc_step;
  // Fetch group
  logic [WORD_W-1:0] fetch_word;
  logic [WORD_W-1:0] next_fetch_word;
  logic              fetch_valid;
  logic              next_fetch_valid;
  // Execute group
  logic [WORD_W-1:0] next_instr_word;
  logic              next_instr_valid;
  logic              exec_keep;

  // Phase decode
  assign phase_first  = (phase == PH_FIRST);
  assign phase_second = (phase == PH_SECOND);
  assign phase_third  = (phase == PH_THIRD);
  assign phase_fourth = (phase == PH_FOURTH);

  // Phase generator: clock divided by four
  always_comb begin
    next_phase = phase;
    unique case (phase)
      PH_FIRST: begin
        next_phase = PH_SECOND;
      end
      PH_SECOND: begin
        next_phase = PH_THIRD;
      end
      PH_THIRD: begin
        next_phase = PH_FOURTH;
      end
      PH_FOURTH: begin
        next_phase = PH_FIRST;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      phase <= PH_FOURTH;
    end else begin
      phase <= next_phase;
    end
  end

  // Cycle-rate output: high over the first two phases
  always_comb begin
    next_rate = 1'b0;
    unique case (next_phase)
      PH_FIRST: begin
        next_rate = 1'b1;
      end
      PH_SECOND: begin
        next_rate = 1'b1;
      end
      PH_THIRD: begin
        next_rate = 1'b0;
      end
      PH_FOURTH: begin
        next_rate = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cycle_rate_output <= 1'b0;
    end else begin
      cycle_rate_output <= next_rate;
    end
  end

  // Redirect requests; interrupt entry wins over a branch
  assign intr_req   = intr_enter && !redirect_pend;
  assign branch_req = branch_take && instr_valid && !redirect_pend;
  assign redirect   = redirect_pend && phase_first;

  // Held until the next first phase, further requests ignored
  always_comb begin
    next_redirect_pend = redirect_pend;
    next_target        = target;
    if (phase_first) begin
      next_redirect_pend = 1'b0;
    end
    if (intr_req) begin
      next_redirect_pend = 1'b1;
      next_target        = INTR_VEC;
    end else if (branch_req) begin
      next_redirect_pend = 1'b1;
      next_target        = branch_target;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      redirect_pend <= 1'b0;
      target        <= RESET_VEC;
    end else begin
      redirect_pend <= next_redirect_pend;
      target        <= next_target;
    end
  end

  // Boot cycle fetches the reset vector before anything runs
  always_comb begin
    next_boot = boot;
    if (phase_first) begin
      next_boot = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      boot <= 1'b1;
    end else begin
      boot <= next_boot;
    end
  end

  // Program counter steps or jumps at the end of the first phase
  assign pc_step = PC_W'(pc + 13'h0001);

  always_comb begin
    next_pc = pc;
    unique case (phase)
      PH_FIRST: begin
        if (redirect) begin
          next_pc = target;
        end else if (!boot) begin
          next_pc = pc_step;
        end
      end
      PH_SECOND: begin
      end
      PH_THIRD: begin
      end
      PH_FOURTH: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pc <= RESET_VEC;
    end else begin
      pc <= next_pc;
    end
  end

  // Fetch slot valid from the fourth phase until the word moves on
  always_comb begin
    next_fetch_valid = fetch_valid;
    unique case (phase)
      PH_FIRST: begin
        next_fetch_valid = 1'b0;
      end
      PH_SECOND: begin
      end
      PH_THIRD: begin
      end
      PH_FOURTH: begin
        // Reset exit edge is not a fetch
        if (!boot) begin
          next_fetch_valid = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fetch_valid <= 1'b0;
    end else begin
      fetch_valid <= next_fetch_valid;
    end
  end

  // Program word captured at the end of the fourth phase
  always_comb begin
    next_fetch_word = fetch_word;
    unique case (phase)
      PH_FIRST: begin
      end
      PH_SECOND: begin
      end
      PH_THIRD: begin
      end
      PH_FOURTH: begin
        if (!boot) begin
          next_fetch_word = prog_data;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fetch_word <= NOP_WORD;
    end else begin
      fetch_word <= next_fetch_word;
    end
  end

  // Flushed or empty slot runs as a no-op
  assign exec_keep = fetch_valid && !redirect;

  always_comb begin
    next_instr_valid = instr_valid;
    unique case (phase)
      PH_FIRST: begin
        next_instr_valid = exec_keep;
      end
      PH_SECOND: begin
      end
      PH_THIRD: begin
      end
      PH_FOURTH: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      instr_valid <= 1'b0;
    end else begin
      instr_valid <= next_instr_valid;
    end
  end

  // Prefetched word moves to execute in the first phase
  always_comb begin
    next_instr_word = instr_word;
    unique case (phase)
      PH_FIRST: begin
        next_instr_word = exec_keep ? fetch_word : NOP_WORD;
      end
      PH_SECOND: begin
      end
      PH_THIRD: begin
      end
      PH_FOURTH: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      instr_word <= NOP_WORD;
    end else begin
      instr_word <= next_instr_word;
    end
  end

  // Upper address bits dropped so fetches wrap into implemented words
  assign prog_addr = pc[IMPL_W-1:0];

  // Data memory strobes only for a word that really executes
  assign data_read  = instr_valid && phase_second;
  assign data_write = instr_valid && phase_fourth;
endmodule

// ---- verif/fes_properties.sv ----
/* fes_sequencer checker; one clock. */
module fes_checker
  import fes_pkg::*; (
  input wire logic clk, nrst, instr_valid, data_read, data_write,
  input wire logic phase_first, phase_second, phase_third, phase_fourth,
  input wire logic cycle_rate_output,
  input wire logic [IMPL_W-1:0] prog_addr,
  input wire logic [WORD_W-1:0] instr_word,
  input wire logic [PC_W-1:0] pc
);
  timeunit 1ns / 1ns;
  wire [3:0] ph = {phase_first, phase_second, phase_third, phase_fourth};
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_HOT: assert property ($onehot(ph)) else $error("phase");
  AST_SEQ: assert property (ph[3] |=> ph[2] ##1 ph[1] ##1 ph[0])
    else $error("order");
  AST_PC: assert property (!ph[3] |=> $stable(pc)) else $error("pc");
  AST_ADR: assert property (prog_addr == pc[IMPL_W-1:0])
    else $error("addr");
  AST_RD: assert property (data_read == (ph[2] && instr_valid))
    else $error("read");
  AST_WR: assert property (data_write == (ph[0] && instr_valid))
    else $error("write");
  AST_RATE: assert property (cycle_rate_output == (ph[3] | ph[2]))
    else $error("rate");
  AST_IR: assert property (!ph[3] |=> $stable(instr_word))
    else $error("word");
endmodule
bind fes_sequencer fes_checker fes_checker_inst (.*);

// ---- verif/fes_prog_mem.sv ----
/* Combinational program memory model. */
module fes_prog_mem
  import fes_pkg::*; (
  input  wire logic [IMPL_W-1:0] prog_addr,
  output logic [WORD_W-1:0] prog_data
);
  timeunit 1ns / 1ns;
  assign prog_data = {2'h2, prog_addr};
endmodule

// ---- verif/tb_top.sv ----
/* fes_sequencer bench. */
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  num_errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top
  import fes_pkg::*;
;
  timeunit 1ns / 1ns;
  logic clk = '0, nrst = '0, branch_take = '0, intr_enter = '0;
  logic instr_valid, phase_first, phase_second, phase_third, phase_fourth;
  logic data_read, data_write, cycle_rate_output;
  logic [PC_W-1:0] branch_target = 13'h1ffe, pc;
  logic [IMPL_W-1:0] prog_addr;
  logic [WORD_W-1:0] prog_data, instr_word;
  int num_errors, cmp_count;
  initial forever #50 clk = ~clk;
  fes_prog_mem fes_prog_mem_inst (.*);
  fes_sequencer fes_sequencer_inst (.*);
  task complete_run;
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task ex(int e, logic [PC_W-1:0] a, p, logic v);
    repeat (e) @(posedge clk);
    #1 `CHK("word", v ? {2'h2, a[IMPL_W-1:0]} : NOP_WORD, instr_word)
    `CHK("pc", {p, v}, {pc, instr_valid})
  endtask
  task boot_run;
    repeat (16) @(posedge clk);
    nrst <= 1'h1;
    ex(2, 0, 0, 1'h0);
    for (int i = 0; i < 4; i++) ex(4, 13'(i), 13'(i + 1), 1'h1);
  endtask
  task redirects;
    @(posedge clk) branch_take <= 1'h1;
    @(posedge clk) branch_take <= 1'h0;
    ex(2, 0, 13'h1ffe, 1'h0);
    ex(4, 13'h1ffe, 13'h1fff, 1'h1);
    @(posedge clk) {branch_take, intr_enter} <= 2'h3;
    @(posedge clk) {branch_take, intr_enter} <= 2'h0;
    ex(2, 0, INTR_VEC, 1'h0);
  endtask
  initial begin
    boot_run();
    redirects();
    complete_run();
  end
endmodule
